// File: hw/acw_ctrl.sv
// Converter control with window compare, APB register slave.
// Assumes conv_tick and the analog result come from the same mclk domain.
//
// Overview of operation
// [RQ1] Window mode field selects match condition
// [RQ2] Mode zero never sets window flag
// [RQ3] Mode one below low, two above high
// [RQ4] Three strictly inside, four outside window
// [RQ5] Sample length extends two-cycle sampling phase
// [RQ6] Input select routes pins, DAC, reference, ground
// [RQ7] New input selection waits for conversion end
// [RQ8] Writing start bit launches one measurement
// [RQ9] Start bit reads one while busy
// [RQ10] Event input starts conversion when enabled
// [RQ11] Window interrupt requires enable and flag
// [RQ12] Result interrupt requires enable and flag
// [RQ13] Window flag set only on matching result
// [RQ14] Window flag cleared by one or read
// [RQ15] Result flag set on each completion
// [RQ16] Result flag cleared by one or read
// [RQ17] Writing zero leaves flags unchanged
// [RQ18] Debug halt freezes block, ignores events
// [RQ19] Debug run keeps converting while halted
// [RQ20] Thresholds apply to final accumulated value
// [RQ21] Thresholds sixteen-bit writable, reset zero
// [RQ22] Reserved window modes behave like zero
// [RQ23] Comparisons unsigned with strict relations
`timescale 1ns/1ps
module acw_ctrl (
  input  wire logic                       mclk,
  input  wire logic                       rst_b,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [acw_pkg::ADDR_W-1:0] paddr,
  input  wire logic [acw_pkg::DATA_W-1:0] pwdata,
  output logic      [acw_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       conv_tick,
  input  wire logic                       evt_start,
  input  wire logic                       cpu_halted,
  input  wire logic                       conv_done,
  input  wire logic [15:0]                conv_data,
  output logic      [4:0]                 input_sel,
  output logic                            sampling,
  output logic                            conv_begin,
  output logic                            irq_result,
  output logic                            irq_window
);
  acw_pkg::acw_state_e state_r;
  logic [2:0]  win_mode_r;
  logic [4:0]  samp_len_r;
  logic [4:0]  pos_sel_r;
  logic        busy_r;
  logic        evt_en_r;
  logic [1:0]  int_en_r;
  logic [1:0]  int_en_nxt;
  logic [1:0]  flags_r;
  logic [1:0]  flags_nxt;
  logic        dbg_run_r;
  logic [15:0] result_r;
  logic [15:0] low_thr_r;
  logic [15:0] high_thr_r;
  logic [5:0]  samp_cnt_r;
  logic [5:0]  samp_end_r;
  logic [4:0]  input_sel_r;
  logic        conv_begin_r;
  logic        sampling_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        irq_result_r;
  logic        irq_window_r;
  logic        frozen;
  logic        wr_en;
  logic        rd_en;
  logic        finish;
  logic        launch;
  logic        win_match;
  logic        mapped;

  assign frozen = cpu_halted && !dbg_run_r;        // RQ18 RQ19
  assign wr_en  = psel && penable && pready_r && pwrite;
  assign rd_en  = psel && penable && pready_r && !pwrite;
  assign finish = state_r == acw_pkg::ST_CONVERT && conv_done;
  assign launch = state_r == acw_pkg::ST_IDLE && busy_r && !frozen;

  function automatic logic hit(input logic [5:0] idx);
    hit = paddr == acw_pkg::reg_addr(idx);
  endfunction : hit

  acw_win_cmp u_win_cmp (
    .mode     (win_mode_r),
    .result   (conv_data),
    .low_thr  (low_thr_r),
    .high_thr (high_thr_r),
    .match    (win_match)
  );

  // APB answer: no wait states, data prepared during the setup cycle
  always_comb begin
    mapped = hit(acw_pkg::IDX_WIN_MODE) || hit(acw_pkg::IDX_SAMP_LEN) ||
             hit(acw_pkg::IDX_POS_SEL) || hit(acw_pkg::IDX_COMMAND) ||
             hit(acw_pkg::IDX_EVT_CTRL) || hit(acw_pkg::IDX_INT_EN) ||
             hit(acw_pkg::IDX_INT_FLAGS) || hit(acw_pkg::IDX_DBG_CTRL) ||
             hit(acw_pkg::IDX_RESULT) || hit(acw_pkg::IDX_WIN_LOW) ||
             hit(acw_pkg::IDX_WIN_HIGH);
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= psel && !penable;
      pslverr_r <= psel && !penable && !mapped;
      prdata_r  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (1'b1)
          hit(acw_pkg::IDX_WIN_MODE):  prdata_r[2:0]  <= win_mode_r;
          hit(acw_pkg::IDX_SAMP_LEN):  prdata_r[4:0]  <= samp_len_r;
          hit(acw_pkg::IDX_POS_SEL):   prdata_r[4:0]  <= pos_sel_r;
          hit(acw_pkg::IDX_COMMAND):   prdata_r[acw_pkg::BIT_START]
                                         <= busy_r; // RQ9
          hit(acw_pkg::IDX_EVT_CTRL):  prdata_r[acw_pkg::BIT_EVT_EN]
                                         <= evt_en_r;
          hit(acw_pkg::IDX_INT_EN):    prdata_r[1:0]  <= int_en_r;
          hit(acw_pkg::IDX_INT_FLAGS): prdata_r[1:0]  <= flags_r;
          hit(acw_pkg::IDX_DBG_CTRL):  prdata_r[acw_pkg::BIT_DBG_RUN]
                                         <= dbg_run_r;
          hit(acw_pkg::IDX_RESULT):    prdata_r[15:0] <= result_r;
          hit(acw_pkg::IDX_WIN_LOW):   prdata_r[15:0] <= low_thr_r;
          hit(acw_pkg::IDX_WIN_HIGH):  prdata_r[15:0] <= high_thr_r;
          default:                     prdata_r       <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Plain read/write configuration
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      win_mode_r <= acw_pkg::RST_WIN_MODE;
      samp_len_r <= acw_pkg::RST_SAMP_LEN;
      pos_sel_r  <= acw_pkg::RST_POS_SEL;
      evt_en_r   <= 1'b0;
      int_en_r   <= acw_pkg::RST_BITS2;
      dbg_run_r  <= 1'b0;
      low_thr_r  <= acw_pkg::RST_WORD16;  // RQ21
      high_thr_r <= acw_pkg::RST_WORD16;  // RQ21
    end else if (wr_en) begin
      if (hit(acw_pkg::IDX_WIN_MODE)) win_mode_r <= pwdata[2:0];
      if (hit(acw_pkg::IDX_SAMP_LEN)) samp_len_r <= pwdata[4:0];
      if (hit(acw_pkg::IDX_POS_SEL))  pos_sel_r  <= pwdata[4:0];
      if (hit(acw_pkg::IDX_EVT_CTRL))
        evt_en_r <= pwdata[acw_pkg::BIT_EVT_EN];
      if (hit(acw_pkg::IDX_INT_EN))   int_en_r   <= pwdata[1:0];
      if (hit(acw_pkg::IDX_DBG_CTRL))
        dbg_run_r <= pwdata[acw_pkg::BIT_DBG_RUN];
      if (hit(acw_pkg::IDX_WIN_LOW))  low_thr_r  <= pwdata[15:0]; // RQ21
      if (hit(acw_pkg::IDX_WIN_HIGH)) high_thr_r <= pwdata[15:0]; // RQ21
    end
  end

  // Start bit: set by software or event, cleared when conversion ends
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      busy_r <= 1'b0;
    end else if (wr_en && hit(acw_pkg::IDX_COMMAND)
                 && pwdata[acw_pkg::BIT_START]) begin
      busy_r <= 1'b1;                                     // RQ8
    end else if (evt_en_r && evt_start && !frozen) begin
      busy_r <= 1'b1;                                     // RQ10 RQ18
    end else if (finish) begin
      busy_r <= 1'b0;                                     // RQ9
    end
  end

  // Conversion sequencer; sampling counted in converter clock ticks
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_r      <= acw_pkg::ST_IDLE;
      samp_cnt_r   <= 6'h00;
      samp_end_r   <= acw_pkg::SAMP_BASE;
      input_sel_r  <= acw_pkg::RST_POS_SEL;
      conv_begin_r <= 1'b0;
      sampling_r   <= 1'b0;
    end else begin
      conv_begin_r <= 1'b0;
      case (state_r)
        acw_pkg::ST_IDLE: begin
          if (launch) begin
            state_r     <= acw_pkg::ST_SAMPLE;
            samp_cnt_r  <= 6'h00;
            samp_end_r  <= acw_pkg::SAMP_BASE + {1'b0, samp_len_r}; // RQ5
            input_sel_r <= acw_pkg::legal_sel(pos_sel_r);      // RQ6 RQ7
            sampling_r  <= 1'b1;
          end
        end
        acw_pkg::ST_SAMPLE: begin
          if (conv_tick && !frozen) begin
            if (samp_cnt_r + 6'h01 == samp_end_r) begin            // RQ5
              state_r      <= acw_pkg::ST_CONVERT;
              conv_begin_r <= 1'b1;
              sampling_r   <= 1'b0;
            end
            samp_cnt_r <= samp_cnt_r + 6'h01;
          end
        end
        acw_pkg::ST_CONVERT: begin
          if (conv_done) begin
            state_r <= acw_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r    <= acw_pkg::ST_IDLE;
          sampling_r <= 1'b0;
        end
      endcase
    end
  end

  // Result capture; conv_data is the final accumulated value
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      result_r <= acw_pkg::RST_WORD16;
    end else if (finish) begin
      result_r <= conv_data;                              // RQ20
    end
  end

  // Flags: hardware set wins over a clear in the same cycle
  always_comb begin
    flags_nxt  = flags_r;
    int_en_nxt = int_en_r;
    if (wr_en && hit(acw_pkg::IDX_INT_EN)) begin
      int_en_nxt = pwdata[1:0];
    end
    if (rd_en && hit(acw_pkg::IDX_RESULT)) begin
      flags_nxt = 2'h0;                                   // RQ14 RQ16
    end
    if (wr_en && hit(acw_pkg::IDX_INT_FLAGS)) begin
      flags_nxt = flags_nxt & ~pwdata[1:0];               // RQ14 RQ16 RQ17
    end
    if (finish) begin
      flags_nxt[acw_pkg::BIT_VAL_RDY] = 1'b1;             // RQ15
      if (win_match) begin
        flags_nxt[acw_pkg::BIT_WIN_MAT] = 1'b1;           // RQ13 RQ20
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      flags_r      <= acw_pkg::RST_BITS2;
      irq_result_r <= 1'b0;
      irq_window_r <= 1'b0;
    end else begin
      flags_r      <= flags_nxt;
      irq_result_r <= flags_nxt[acw_pkg::BIT_VAL_RDY]
                      && int_en_nxt[acw_pkg::BIT_VAL_RDY]; // RQ12
      irq_window_r <= flags_nxt[acw_pkg::BIT_WIN_MAT]
                      && int_en_nxt[acw_pkg::BIT_WIN_MAT]; // RQ11
    end
  end

  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign input_sel  = input_sel_r;
  assign sampling   = sampling_r;
  assign conv_begin = conv_begin_r;
  assign irq_result = irq_result_r;
  assign irq_window = irq_window_r;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  property p_flag_cause;
    $rose(flags_r[acw_pkg::BIT_WIN_MAT]) |->
      $past(finish && win_match);
  endproperty
  a_flag_cause: assert property (p_flag_cause) // RQ13
    else $error("window flag rose without a matching completion");

  property p_mode_none;
    $rose(flags_r[acw_pkg::BIT_WIN_MAT]) |->
      $past(win_mode_r) >= acw_pkg::WM_BELOW &&
      $past(win_mode_r) <= acw_pkg::WM_OUTSIDE;
  endproperty
  a_mode_none: assert property (p_mode_none) // RQ2
    else $error("window flag set in disabled or reserved mode");

  property p_below;
    finish && win_mode_r == acw_pkg::WM_BELOW && conv_data < low_thr_r
      |=> flags_r[acw_pkg::BIT_WIN_MAT] && result_r == $past(conv_data);
  endproperty
  a_below: assert property (p_below) // RQ3
    else $error("below-mode match not flagged");

  property p_inside;
    finish && win_mode_r == acw_pkg::WM_INSIDE &&
      conv_data > low_thr_r && conv_data < high_thr_r
      |=> flags_r[acw_pkg::BIT_WIN_MAT];
  endproperty
  a_inside: assert property (p_inside) // RQ4
    else $error("inside-mode match not flagged");

  property p_samp_len;
    state_r == acw_pkg::ST_SAMPLE && conv_tick && !frozen &&
      samp_cnt_r == samp_end_r - 6'h01
      |=> state_r == acw_pkg::ST_CONVERT && conv_begin_r ##1 !conv_begin_r;
  endproperty
  a_samp_len: assert property (p_samp_len) // RQ5
    else $error("sampling phase length wrong");

  property p_sel_hold;
    state_r != acw_pkg::ST_IDLE && $past(state_r) != acw_pkg::ST_IDLE
      |-> $stable(input_sel_r);
  endproperty
  a_sel_hold: assert property (p_sel_hold) // RQ7
    else $error("input selection changed during conversion");

  property p_busy;
    state_r != acw_pkg::ST_IDLE |-> busy_r;
  endproperty
  a_busy: assert property (p_busy) // RQ9
    else $error("start bit low while converting");

  property p_launch;
    wr_en && hit(acw_pkg::IDX_COMMAND) && pwdata[acw_pkg::BIT_START] &&
      state_r == acw_pkg::ST_IDLE && !busy_r && !cpu_halted
      |=> busy_r ##1 (state_r == acw_pkg::ST_SAMPLE || frozen);
  endproperty
  a_launch: assert property (p_launch) // RQ8
    else $error("start command did not launch");

  property p_irq;
    irq_window_r == (flags_r[acw_pkg::BIT_WIN_MAT] &&
                     int_en_r[acw_pkg::BIT_WIN_MAT]) &&
    irq_result_r == (flags_r[acw_pkg::BIT_VAL_RDY] &&
                     int_en_r[acw_pkg::BIT_VAL_RDY]);
  endproperty
  a_irq: assert property (p_irq) // RQ11
    else $error("interrupt request not enable and flag");

  property p_zero_write;
    wr_en && hit(acw_pkg::IDX_INT_FLAGS) && pwdata[1:0] == 2'h0
      |=> (flags_r & $past(flags_r)) == $past(flags_r);
  endproperty
  a_zero_write: assert property (p_zero_write) // RQ17
    else $error("writing zero changed a flag");

  property p_halt;
    frozen && state_r == acw_pkg::ST_IDLE |=> state_r == acw_pkg::ST_IDLE;
  endproperty
  a_halt: assert property (p_halt) // RQ18
    else $error("conversion launched during debug halt");
endmodule : acw_ctrl

// File: hw/acw_pkg.sv
// Package for the converter control and window compare block.
// Assumes APB with 32-bit data; registers are one word at four times index.
package acw_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_WIN_MODE  = 6'h04;
  localparam logic [5:0] IDX_SAMP_LEN  = 6'h05;
  localparam logic [5:0] IDX_POS_SEL   = 6'h06;
  localparam logic [5:0] IDX_COMMAND   = 6'h08;
  localparam logic [5:0] IDX_EVT_CTRL  = 6'h09;
  localparam logic [5:0] IDX_INT_EN    = 6'h0A;
  localparam logic [5:0] IDX_INT_FLAGS = 6'h0B;
  localparam logic [5:0] IDX_DBG_CTRL  = 6'h0C;
  localparam logic [5:0] IDX_RESULT    = 6'h10;
  localparam logic [5:0] IDX_WIN_LOW   = 6'h12;
  localparam logic [5:0] IDX_WIN_HIGH  = 6'h14;

  // Field positions
  localparam int unsigned BIT_START   = 0;
  localparam int unsigned BIT_EVT_EN  = 0;
  localparam int unsigned BIT_VAL_RDY = 0;
  localparam int unsigned BIT_WIN_MAT = 1;
  localparam int unsigned BIT_DBG_RUN = 0;

  // Reset values
  localparam logic [2:0]  RST_WIN_MODE = 3'h0;
  localparam logic [4:0]  RST_SAMP_LEN = 5'h00;
  localparam logic [4:0]  RST_POS_SEL  = 5'h00;
  localparam logic [15:0] RST_WORD16   = 16'h0000;
  localparam logic [1:0]  RST_BITS2    = 2'h0;

  // Default sampling phase in converter clock cycles
  localparam logic [5:0] SAMP_BASE = 6'h02;

  // Window compare modes
  localparam logic [2:0] WM_NONE    = 3'h0;
  localparam logic [2:0] WM_BELOW   = 3'h1;
  localparam logic [2:0] WM_ABOVE   = 3'h2;
  localparam logic [2:0] WM_INSIDE  = 3'h3;
  localparam logic [2:0] WM_OUTSIDE = 3'h4;

  // Positive input codes
  localparam logic [4:0] SEL_PIN_LAST = 5'h0A;
  localparam logic [4:0] SEL_DAC_OUT  = 5'h1C;
  localparam logic [4:0] SEL_INT_REF  = 5'h1D;
  localparam logic [4:0] SEL_GROUND   = 5'h1F;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_SAMPLE  = 3'b010,
    ST_CONVERT = 3'b100
  } acw_state_e;

  function automatic logic [ADDR_W-1:0] reg_addr(input logic [5:0] idx);
    reg_addr = {idx, 2'b00};
  endfunction : reg_addr

  // Reserved input codes fall back to ground
  function automatic logic [4:0] legal_sel(input logic [4:0] code);
    if (code <= SEL_PIN_LAST || code == SEL_DAC_OUT ||
        code == SEL_INT_REF || code == SEL_GROUND) begin
      legal_sel = code;
    end else begin
      legal_sel = SEL_GROUND;
    end
  endfunction : legal_sel
endpackage : acw_pkg

// File: hw/acw_win_cmp.sv
// Window comparator: unsigned 16-bit result against low and high limits.
// Assumes inputs are stable in the cycle the caller samples the match.
`timescale 1ns/1ps
module acw_win_cmp (
  input  wire logic [2:0]  mode,
  input  wire logic [15:0] result,
  input  wire logic [15:0] low_thr,
  input  wire logic [15:0] high_thr,
  output logic             match
);
  logic below;
  logic above;

  assign below = result < low_thr;  // RQ23
  assign above = result > high_thr; // RQ23

  always_comb begin
    case (mode) // RQ1
      acw_pkg::WM_BELOW:   match = below;          // RQ3
      acw_pkg::WM_ABOVE:   match = above;          // RQ3
      acw_pkg::WM_INSIDE:  match = !below && !above
                                   && result != low_thr
                                   && result != high_thr; // RQ4
      acw_pkg::WM_OUTSIDE: match = below || above; // RQ4
      default:             match = 1'b0;           // RQ2 RQ22
    endcase
  end
endmodule : acw_win_cmp

// File: verif/adc_control_window_compare_bench.sv
// Self-checking bench for the converter control block over APB.
// Assumes acw_pkg and acw_ctrl compiled first; the bench drives every port.
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    compares++; \
    if ((got) !== (ex)) begin \
      fails++; \
      $display("MISMATCH %s exp=%0h got=%0h", nm, ex, got); \
    end \
  end
module adc_control_window_compare_bench;
  typedef struct {
    logic [2:0]  mode;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] d;
    logic        hit;
    logic [4:0]  sel;
    logic [4:0]  app;
    logic [4:0]  slen;
  } acw_case_s;

  logic        mclk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        conv_tick;
  logic        evt_start;
  logic        cpu_halted;
  logic        conv_done;
  logic [15:0] conv_data;
  logic [4:0]  input_sel;
  logic        sampling;
  logic        conv_begin;
  logic        irq_result;
  logic        irq_window;
  int          fails;
  int          compares;
  logic [31:0] rd;
  logic        err;
  acw_case_s   tab [12];
  logic [5:0]  regs [11];

  acw_ctrl u_acw_ctrl (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_tick(conv_tick),
    .evt_start(evt_start), .cpu_halted(cpu_halted),
    .conv_done(conv_done), .conv_data(conv_data),
    .input_sel(input_sel), .sampling(sampling),
    .conv_begin(conv_begin), .irq_result(irq_result),
    .irq_window(irq_window)
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  // One APB transfer; entered and left just after a rising edge
  task automatic apb(input logic wr, input logic [5:0] idx,
                     input logic [31:0] wd);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge mclk);
    end
    if (n == 20) fails++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  task automatic chk_rd(input string nm, input logic [5:0] idx,
                        input logic [31:0] ex);
    apb(1'b0, idx, 32'h0000_0000);
    `CHK(nm, ex, rd)
  endtask : chk_rd

  // Full conversion; nsel is written to input select mid-run
  task automatic run(input logic [15:0] d, input logic [4:0] slen,
                     input logic ev, input logic [4:0] nsel,
                     input logic [4:0] app);
    int n;
    int t;
    n = 0;
    t = 0;
    if (ev) begin
      evt_start <= 1'b1;
      @(posedge mclk);
      evt_start <= 1'b0;
      @(posedge mclk);
    end else begin
      apb(1'b1, acw_pkg::IDX_COMMAND, 32'h0000_0001);
    end
    while (sampling !== 1'b1 && n < 20) begin
      n++;
      @(posedge mclk);
    end
    `CHK("sampling", 1'b1, sampling)
    chk_rd("busy", acw_pkg::IDX_COMMAND, 32'h0000_0001);
    apb(1'b1, acw_pkg::IDX_POS_SEL, {27'h0, nsel});
    `CHK("held input", app, input_sel)
    while (conv_begin !== 1'b1 && t < 40) begin
      conv_tick <= 1'b1;
      @(posedge mclk);
      conv_tick <= 1'b0;
      @(posedge mclk);
      t++;
    end
    `CHK("ticks", int'(slen) + 2, t)
    `CHK("sample end", 1'b0, sampling)
    conv_done <= 1'b1;
    conv_data <= d;
    @(posedge mclk);
    `CHK("begin pulse", 1'b0, conv_begin)
    conv_done <= 1'b0;
    conv_data <= ~d;
    @(posedge mclk);
    chk_rd("idle", acw_pkg::IDX_COMMAND, 32'h0000_0000);
    `CHK("applied input", app, input_sel)
  endtask : run

  initial begin
    #(4 * 30000);
    fails++;
    summarize();
  end

  initial begin
    tab = '{
      '{3'h0, 16'h000A, 16'h0014, 16'h0005, 1'b0, 5'h00, 5'h00, 5'h00},
      '{3'h1, 16'h000A, 16'h0014, 16'h0009, 1'b1, 5'h0A, 5'h0A, 5'h01},
      '{3'h1, 16'h000A, 16'h0014, 16'h000A, 1'b0, 5'h1C, 5'h1C, 5'h1F},
      '{3'h2, 16'h000A, 16'h0014, 16'h0015, 1'b1, 5'h1D, 5'h1D, 5'h02},
      '{3'h2, 16'h7FFF, 16'h7FFF, 16'h8000, 1'b1, 5'h1F, 5'h1F, 5'h00},
      '{3'h2, 16'h000A, 16'h0014, 16'h0014, 1'b0, 5'h1E, 5'h1F, 5'h00},
      '{3'h3, 16'h000A, 16'h0014, 16'h000F, 1'b1, 5'h03, 5'h03, 5'h00},
      '{3'h3, 16'h000A, 16'h0014, 16'h000A, 1'b0, 5'h00, 5'h00, 5'h00},
      '{3'h4, 16'h000A, 16'h0014, 16'h0009, 1'b1, 5'h07, 5'h07, 5'h00},
      '{3'h4, 16'h000A, 16'h0014, 16'h000F, 1'b0, 5'h00, 5'h00, 5'h00},
      '{3'h5, 16'h000A, 16'h0014, 16'h0005, 1'b0, 5'h00, 5'h00, 5'h00},
      '{3'h7, 16'h000A, 16'h0014, 16'hFFFF, 1'b0, 5'h00, 5'h00, 5'h00}};
    regs = '{6'h04, 6'h05, 6'h06, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C,
             6'h10, 6'h12, 6'h14};
    fails = 0;
    compares = 0;
    rst_b = 1'b0;
    {psel, penable, pwrite, conv_tick, evt_start} = 5'h00;
    {cpu_halted, conv_done} = 2'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    conv_data = 16'h0000;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    foreach (regs[i]) chk_rd("reset value", regs[i], 32'h0000_0000);
    apb(1'b0, 6'h3F, 32'h0000_0000);
    `CHK("unmapped error", 1'b1, err)
    apb(1'b1, acw_pkg::IDX_WIN_LOW, 32'h0000_ABCD);
    chk_rd("low threshold", acw_pkg::IDX_WIN_LOW, 32'h0000_ABCD);
    $display("test registers done");

    apb(1'b1, acw_pkg::IDX_INT_EN, 32'h0000_0003);
    apb(1'b1, acw_pkg::IDX_POS_SEL, {27'h0, tab[0].sel});
    foreach (tab[i]) begin
      apb(1'b1, acw_pkg::IDX_WIN_MODE, {29'h0, tab[i].mode});
      apb(1'b1, acw_pkg::IDX_WIN_LOW, {16'h0, tab[i].lo});
      apb(1'b1, acw_pkg::IDX_WIN_HIGH, {16'h0, tab[i].hi});
      apb(1'b1, acw_pkg::IDX_SAMP_LEN, {27'h0, tab[i].slen});
      run(tab[i].d, tab[i].slen, 1'b0, tab[(i + 1) % 12].sel, tab[i].app);
      `CHK("window irq", tab[i].hit, irq_window)
      `CHK("result irq", 1'b1, irq_result)
      chk_rd("flags", acw_pkg::IDX_INT_FLAGS, {30'h0, tab[i].hit, 1'b1});
      chk_rd("result", acw_pkg::IDX_RESULT, {16'h0, tab[i].d});
      chk_rd("flags after read", acw_pkg::IDX_INT_FLAGS, 32'h0);
    end
    $display("test window modes done");

    apb(1'b1, acw_pkg::IDX_INT_EN, 32'h0000_0000);
    apb(1'b1, acw_pkg::IDX_WIN_MODE, 32'h0000_0001);
    apb(1'b1, acw_pkg::IDX_SAMP_LEN, 32'h0000_0000);
    run(16'h0009, 5'h00, 1'b0, 5'h00, 5'h00);
    `CHK("masked window irq", 1'b0, irq_window)
    `CHK("masked result irq", 1'b0, irq_result)
    apb(1'b1, acw_pkg::IDX_INT_FLAGS, 32'h0000_0000);
    chk_rd("flags zero write", acw_pkg::IDX_INT_FLAGS, 32'h3);
    apb(1'b1, acw_pkg::IDX_INT_EN, 32'h0000_0003);
    `CHK("late window irq", 1'b1, irq_window)
    `CHK("late result irq", 1'b1, irq_result)
    apb(1'b1, acw_pkg::IDX_INT_FLAGS, 32'h0000_0002);
    chk_rd("window cleared", acw_pkg::IDX_INT_FLAGS, 32'h1);
    `CHK("cleared window irq", 1'b0, irq_window)
    apb(1'b1, acw_pkg::IDX_INT_FLAGS, 32'h0000_0001);
    chk_rd("result cleared", acw_pkg::IDX_INT_FLAGS, 32'h0);
    `CHK("cleared result irq", 1'b0, irq_result)
    $display("test flag clearing done");

    evt_start <= 1'b1;
    @(posedge mclk);
    evt_start <= 1'b0;
    repeat (3) @(posedge mclk);
    chk_rd("event disabled", acw_pkg::IDX_COMMAND, 32'h0);
    apb(1'b1, acw_pkg::IDX_EVT_CTRL, 32'h0000_0001);
    run(16'h0020, 5'h00, 1'b1, 5'h00, 5'h00);
    chk_rd("event flags", acw_pkg::IDX_INT_FLAGS, 32'h1);
    chk_rd("event result", acw_pkg::IDX_RESULT, 32'h20);
    $display("test event start done");

    cpu_halted <= 1'b1;
    evt_start <= 1'b1;
    @(posedge mclk);
    evt_start <= 1'b0;
    repeat (3) @(posedge mclk);
    chk_rd("halted event", acw_pkg::IDX_COMMAND, 32'h0);
    `CHK("halted sampling", 1'b0, sampling)
    apb(1'b1, acw_pkg::IDX_DBG_CTRL, 32'h0000_0001);
    run(16'h0030, 5'h00, 1'b1, 5'h00, 5'h00);
    chk_rd("halted result", acw_pkg::IDX_RESULT, 32'h30);
    apb(1'b1, acw_pkg::IDX_DBG_CTRL, 32'h0000_0000);
    apb(1'b1, acw_pkg::IDX_COMMAND, 32'h0000_0001);
    chk_rd("halted start", acw_pkg::IDX_COMMAND, 32'h1);
    `CHK("halted start waits", 1'b0, sampling)
    cpu_halted <= 1'b0;
    run(16'h0040, 5'h00, 1'b1, 5'h00, 5'h00);
    chk_rd("resumed result", acw_pkg::IDX_RESULT, 32'h40);
    $display("test debug halt done");
    summarize();
  end
endmodule : adc_control_window_compare_bench
